// ### hw/eewr_map.vh
// constants for the two-wire eeprom write target
`ifndef EEWR_MAP_VH
`define EEWR_MAP_VH

// ==========================================================
// address byte layout
`define EEWR_TYPE_MSB      7
`define EEWR_TYPE_LSB      4
`define EEWR_SEL_MSB       3
`define EEWR_SEL_LSB       1
`define EEWR_RW_BIT        0
// arbitrary neutral value, not a real part code
`define EEWR_TYPE_CODE     4'h5

// ==========================================================
// array and page layout
`define EEWR_ADDR_W        15
`define EEWR_HI_MSB        14
`define EEWR_HI_LSB        8
`define EEWR_PAGE_MSB      14
`define EEWR_PAGE_LSB      6
`define EEWR_OFS_W         6
`define EEWR_PAGE_BYTES    64
`define EEWR_BYTE_BITS     8

// ==========================================================
// timing
`define EEWR_CLK_KHZ       40000
`define EEWR_WC_TIME_US    5000
// 5 ms in 25 ns core clock cycles, sized for the 24-bit timer
`define EEWR_WC_CYCLES     24'd200000
`define EEWR_NOISE_NS      100
// 100 ns in core clock cycles, sized for the 3-bit filter count
`define EEWR_NOISE_CYCLES  3'd4

// ==========================================================
// reset values
`define EEWR_ADDR_RST      15'h0000
`define EEWR_BYTE_RST      8'h00

`endif

// ### hw/eewr_fifo.v
// small valid/ready fifo between the bus engine and the page buffer
`timescale 1ns/1ps
`include "eewr_map.vh"

module eewr_fifo #(
  parameter W  = 14,
  parameter D  = 4,
  parameter AW = 2
) (
  // clock, reset, enable
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire          ce,
  // fill side
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output wire          in_ready,
  // drain side
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready
);

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW:0]   wr_ptr_reg;
  reg  [AW:0]   rd_ptr_reg;
  wire          do_push;
  wire          do_pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign do_push   = ce && in_valid && in_ready;
  assign do_pop    = ce && out_valid && out_ready;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

endmodule

// ### hw/eewr_page.v
// 64-byte page buffer and internally timed programming cycle
`timescale 1ns/1ps
`include "eewr_map.vh"

module eewr_page #(
  parameter [23:0] PROG_CYCLES = `EEWR_WC_CYCLES
) (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        ce,
  // control from the bus engine
  input  wire        clear,
  input  wire        commit,
  input  wire [8:0]  page_base,
  // byte stream: offset and data
  input  wire        in_valid,
  input  wire [13:0] in_data,
  output wire        in_ready,
  // state and array write port
  output wire        busy,
  output reg         mem_wr_en,
  output reg  [14:0] mem_wr_addr,
  output reg  [7:0]  mem_wr_data
);

  localparam ST_FILL = 1'b0;
  localparam ST_PROG = 1'b1;

  reg  [7:0]  page_mem [0:`EEWR_PAGE_BYTES-1];
  reg  [63:0] vld_reg;
  reg         state_reg;
  reg  [6:0]  idx_reg;
  reg  [23:0] tmr_reg;
  reg  [8:0]  base_reg;

  assign in_ready = (state_reg == ST_FILL);
  assign busy     = (state_reg == ST_PROG);

  always @(posedge core_clk) begin
    if (ce && in_valid && in_ready) begin
      page_mem[in_data[13:8]] <= in_data[7:0];
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg   <= ST_FILL;
      vld_reg     <= 64'h0;
      idx_reg     <= 7'h00;
      tmr_reg     <= 24'h000000;
      base_reg    <= 9'h000;
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= `EEWR_ADDR_RST;
      mem_wr_data <= `EEWR_BYTE_RST;
    end else if (ce) begin
      mem_wr_en <= 1'b0;
      case (state_reg)
        ST_FILL: begin
          if (clear) begin
            vld_reg <= 64'h0;
          end else if (commit) begin
            state_reg <= ST_PROG;
            base_reg  <= page_base;
            idx_reg   <= 7'h00;
            tmr_reg   <= 24'h000000;
          end else if (in_valid) begin
            // a wrapped offset simply overwrites the earlier byte
            vld_reg[in_data[13:8]] <= 1'b1;
          end
        end
        ST_PROG: begin
          tmr_reg <= tmr_reg + 24'h000001;
          if (!idx_reg[6]) begin
            idx_reg <= idx_reg + 7'h01;
            if (vld_reg[idx_reg[5:0]]) begin
              mem_wr_en   <= 1'b1;
              mem_wr_addr <= {base_reg, idx_reg[5:0]};
              mem_wr_data <= page_mem[idx_reg[5:0]];
            end
          end
          if (tmr_reg == PROG_CYCLES - 24'h000001) begin
            state_reg <= ST_FILL;
            vld_reg   <= 64'h0;
          end
        end
        default: begin
          state_reg <= ST_FILL;
        end
      endcase
    end
  end

endmodule

// ### hw/eewr_target.v
// two-wire bus target: addressing, acknowledge and page write sequencing
//
// Function
// - address byte: 4-bit type code, 3-bit select high to low, direction
// - wrong type or select code returns to standby, line stays released
// - direction zero starts a write, one starts a read
// - matching address byte gets a zero acknowledge, then the transaction
// - start is data falling with clock high; every transaction begins so
// - stop is data rising with clock high; ends a read into standby
// - stop in a write launches the timed programming cycle, then standby; here only once at least one data byte has been accepted
// - bus activity is ignored while programming runs
// - ninth clock: receiver drives acknowledge low, sender releases line
// - read byte: release on ninth clock, zero acknowledge gives next byte
// - no-acknowledge then stop ends a read into standby
// - no acknowledge and no stop: line stays released, no more bytes
// - write takes two memory address bytes then data, each acknowledged
// - further data bytes replace the stop; up to 64 go in one cycle
// - six low address bits step per byte and wrap inside the page
// - protect high: address bytes acked, first data nacked, nothing written
// - protect low: every location may be written
// - reads work whatever the protect level
// - an unconnected select strap compares as low
// - data sampled on clock rise, driven after clock fall
// - address byte is nacked while programming, acked after it
// - programming ends at most 5 ms after the stop
// - read data leaves most significant bit first
`timescale 1ns/1ps
`include "eewr_map.vh"

module eewr_target #(
  parameter [23:0] PROG_CYCLES = `EEWR_WC_CYCLES,
  parameter        FIFO_DEPTH  = 4,
  parameter        FIFO_AW     = 2
) (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        ce,
  // bus pins
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  // straps and protect
  input  wire [2:0]  strap_select_pins,
  input  wire [2:0]  strap_open,
  input  wire        wp,
  // array read port
  output wire [14:0] mem_rd_addr,
  input  wire [7:0]  mem_rd_data,
  // array write port
  output wire        mem_wr_en,
  output wire [14:0] mem_wr_addr,
  output wire [7:0]  mem_wr_data,
  // status
  output wire        prog_busy,
  output reg         write_refused
);

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV  = 3'd1;
  localparam [2:0] ST_AHI  = 3'd2;
  localparam [2:0] ST_ALO  = 3'd3;
  localparam [2:0] ST_WDAT = 3'd4;
  localparam [2:0] ST_RDAT = 3'd5;

  localparam [2:0] NOISE_N = `EEWR_NOISE_CYCLES;

  // ==========================================================
  // glitch filter: a level is taken after NOISE_N stable cycles
  function [3:0] filt_next;
    input       raw;
    input [3:0] cur;
    begin
      if (raw == cur[3]) begin
        filt_next = {cur[3], 3'd0};
      end else if (cur[2:0] == NOISE_N - 3'd1) begin
        filt_next = {raw, 3'd0};
      end else begin
        filt_next = {cur[3], cur[2:0] + 3'd1};
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg        scl_m_reg;
  reg        scl_s_reg;
  reg        sda_m_reg;
  reg        sda_s_reg;
  reg        wp_m_reg;
  reg        wp_s_reg;
  reg  [5:0] strap_m_reg;
  reg  [5:0] strap_s_reg;
  reg  [3:0] scl_f_reg;
  reg  [3:0] sda_f_reg;
  reg        scl_p_reg;
  reg        sda_p_reg;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      scl_m_reg   <= 1'b1;
      scl_s_reg   <= 1'b1;
      sda_m_reg   <= 1'b1;
      sda_s_reg   <= 1'b1;
      wp_m_reg    <= 1'b0;
      wp_s_reg    <= 1'b0;
      strap_m_reg <= 6'h00;
      strap_s_reg <= 6'h00;
      scl_f_reg   <= 4'h8;
      sda_f_reg   <= 4'h8;
      scl_p_reg   <= 1'b1;
      sda_p_reg   <= 1'b1;
    end else if (ce) begin
      scl_m_reg   <= scl_in;
      scl_s_reg   <= scl_m_reg;
      sda_m_reg   <= sda_in;
      sda_s_reg   <= sda_m_reg;
      wp_m_reg    <= wp;
      wp_s_reg    <= wp_m_reg;
      strap_m_reg <= {strap_open, strap_select_pins};
      strap_s_reg <= strap_m_reg;
      scl_f_reg   <= filt_next(scl_s_reg, scl_f_reg);
      sda_f_reg   <= filt_next(sda_s_reg, sda_f_reg);
      scl_p_reg   <= scl_f_reg[3];
      sda_p_reg   <= sda_f_reg[3];
    end
  end

  wire scl_q = scl_f_reg[3];
  wire sda_q = sda_f_reg[3];
  wire bus_start = scl_q && scl_p_reg && sda_p_reg && !sda_q;
  wire bus_stop  = scl_q && scl_p_reg && !sda_p_reg && sda_q;
  wire scl_rise  = scl_q && !scl_p_reg;
  wire scl_fall  = !scl_q && scl_p_reg;
  // an open strap is forced low before the compare
  wire [2:0] strap_eff = strap_s_reg[2:0] & ~strap_s_reg[5:3];

  // ==========================================================
  // bus engine
  reg  [2:0]  state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  out_reg;
  reg  [14:0] addr_reg;
  reg         oe_reg;
  reg         ack_ph_reg;
  reg         rx_ack_reg;
  reg         had_data_reg;
  reg         push_reg;
  reg  [13:0] push_data_reg;
  reg         commit_reg;
  reg         clear_reg;
  wire        fifo_ready;
  wire        busy;
  wire        dev_match;

  assign dev_match = (shift_reg[`EEWR_TYPE_MSB:`EEWR_TYPE_LSB] == `EEWR_TYPE_CODE) &&
                     (shift_reg[`EEWR_SEL_MSB:`EEWR_SEL_LSB] == strap_eff);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'd0;
      shift_reg     <= `EEWR_BYTE_RST;
      out_reg       <= `EEWR_BYTE_RST;
      addr_reg      <= `EEWR_ADDR_RST;
      oe_reg        <= 1'b0;
      ack_ph_reg    <= 1'b0;
      rx_ack_reg    <= 1'b0;
      had_data_reg  <= 1'b0;
      push_reg      <= 1'b0;
      push_data_reg <= 14'h0000;
      commit_reg    <= 1'b0;
      clear_reg     <= 1'b0;
      write_refused <= 1'b0;
    end else if (ce) begin
      push_reg      <= 1'b0;
      commit_reg    <= 1'b0;
      clear_reg     <= 1'b0;
      write_refused <= 1'b0;
      if (bus_start) begin
        // restart address reception from bit zero
        state_reg   <= ST_DEV;
        bit_cnt_reg <= 4'd0;
        oe_reg      <= 1'b0;
        ack_ph_reg  <= 1'b0;
        rx_ack_reg  <= 1'b0;
      end else if (bus_stop) begin
        if (state_reg == ST_WDAT && had_data_reg) begin
          commit_reg <= 1'b1;
        end
        state_reg  <= ST_IDLE;
        oe_reg     <= 1'b0;
        ack_ph_reg <= 1'b0;
      end else if (state_reg != ST_IDLE && scl_rise) begin
        if (bit_cnt_reg != 4'd8) begin
          shift_reg   <= {shift_reg[6:0], sda_q};
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
        end else begin
          bit_cnt_reg <= 4'd0;
          if (state_reg == ST_RDAT && !rx_ack_reg) begin
            if (sda_q) begin
              // no acknowledge: stay released until start or stop
              state_reg <= ST_IDLE;
            end else begin
              addr_reg <= addr_reg + 15'h0001;
            end
          end
        end
      end else if (state_reg != ST_IDLE && scl_fall) begin
        if (bit_cnt_reg == 4'd8 && !ack_ph_reg) begin
          ack_ph_reg <= 1'b1;
          case (state_reg)
            ST_DEV: begin
              // a busy device stays silent, which reads as a nack
              if (dev_match && !busy) begin
                oe_reg     <= 1'b1;
                rx_ack_reg <= 1'b1;
                state_reg  <= shift_reg[`EEWR_RW_BIT] ? ST_RDAT : ST_AHI;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
            ST_AHI: begin
              addr_reg[`EEWR_HI_MSB:`EEWR_HI_LSB] <= shift_reg[6:0];
              oe_reg     <= 1'b1;
              rx_ack_reg <= 1'b1;
              state_reg  <= ST_ALO;
            end
            ST_ALO: begin
              addr_reg[7:0] <= shift_reg;
              oe_reg        <= 1'b1;
              rx_ack_reg    <= 1'b1;
              had_data_reg  <= 1'b0;
              clear_reg     <= 1'b1;
              state_reg     <= ST_WDAT;
            end
            ST_WDAT: begin
              // protect is read live, so it must not move mid-page
              if (!wp_s_reg && fifo_ready) begin
                push_reg      <= 1'b1;
                push_data_reg <= {addr_reg[`EEWR_OFS_W-1:0], shift_reg};
                addr_reg[`EEWR_OFS_W-1:0] <= addr_reg[`EEWR_OFS_W-1:0] + 6'h01;
                had_data_reg  <= 1'b1;
                oe_reg        <= 1'b1;
                rx_ack_reg    <= 1'b1;
              end else begin
                write_refused <= 1'b1;
                had_data_reg  <= 1'b0;
                state_reg     <= ST_IDLE;
              end
            end
            ST_RDAT: begin
              oe_reg     <= 1'b0;
              rx_ack_reg <= 1'b0;
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end else if (bit_cnt_reg == 4'd0 && ack_ph_reg) begin
          ack_ph_reg <= 1'b0;
          rx_ack_reg <= 1'b0;
          if (state_reg == ST_RDAT) begin
            out_reg <= mem_rd_data;
            oe_reg  <= ~mem_rd_data[7];
          end else begin
            oe_reg <= 1'b0;
          end
        end else if (state_reg == ST_RDAT && !ack_ph_reg) begin
          oe_reg <= ~out_reg[3'd7 - bit_cnt_reg[2:0]];
        end
      end
    end
  end

  // ==========================================================
  // write path: fifo then page buffer
  wire        pg_valid;
  wire [13:0] pg_data;
  wire        pg_ready;

  eewr_fifo #(
    .W  (14),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (push_reg),
    .in_data   (push_data_reg),
    .in_ready  (fifo_ready),
    .out_valid (pg_valid),
    .out_data  (pg_data),
    .out_ready (pg_ready)
  );

  eewr_page #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_page (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .clear       (clear_reg),
    .commit      (commit_reg),
    .page_base   (addr_reg[`EEWR_PAGE_MSB:`EEWR_PAGE_LSB]),
    .in_valid    (pg_valid),
    .in_data     (pg_data),
    .in_ready    (pg_ready),
    .busy        (busy),
    .mem_wr_en   (mem_wr_en),
    .mem_wr_addr (mem_wr_addr),
    .mem_wr_data (mem_wr_data)
  );

  // open drain: only ever pulls low
  assign sda_out     = 1'b0;
  assign sda_oe      = oe_reg;
  assign mem_rd_addr = addr_reg;
  assign prog_busy   = busy;

endmodule

// ### test/eewr_target_assertions.sv
// concurrent checks on the ports of the two-wire eeprom write target
`timescale 1ns/1ps
// ==================
// checker
module eewr_target_assertions #(
  parameter [23:0] PROG_CYCLES = 24'd200000
) (
  // clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // bus pins
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe,
  // protect, write port, status
  input wire        wp,
  input wire        mem_wr_en,
  input wire [14:0] mem_wr_addr,
  input wire        prog_busy,
  input wire        write_refused
);
  reg [23:0] busy_cnt_reg;
  reg [7:0]  fall_age_reg;
  reg [8:0]  page_reg;
  reg        wr_seen_reg;
  // fall_age counts from the raw pin fall, so it includes the input filter delay
  always @(posedge core_clk) begin
    if (!rst_n) begin
      busy_cnt_reg <= 24'h0;
      fall_age_reg <= 8'hff;
      page_reg     <= 9'h0;
      wr_seen_reg  <= 1'b0;
    end else begin
      busy_cnt_reg <= prog_busy ? busy_cnt_reg + 24'h1 : 24'h0;
      if ($fell(scl_in))
        fall_age_reg <= 8'h0;
      else if (fall_age_reg != 8'hff)
        fall_age_reg <= fall_age_reg + 8'h1;
      wr_seen_reg <= prog_busy & (wr_seen_reg | mem_wr_en);
      if (mem_wr_en)
        page_reg <= mem_wr_addr[14:6];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  drive_low_only_a: assert property ($rose(sda_oe) |-> !sda_out && !scl_in)
    else $error("data line driven high or pulled while clock high");
  oe_after_fall_a: assert property ($rose(sda_oe) |-> fall_age_reg inside {[4:10]})
    else $error("data pulled low away from a clock fall");
  oe_holds_bit_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("data pull dropped within a bit");
  busy_silent_a: assert property (prog_busy |-> !sda_oe)
    else $error("target answered while programming");
  busy_length_a: assert property ($fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("programming length wrong");
  write_in_busy_a: assert property (mem_wr_en |-> prog_busy)
    else $error("array written outside programming");
  protect_write_a: assert property (mem_wr_en |-> !wp)
    else $error("array written while protected");
  page_bound_a: assert property (mem_wr_en && wr_seen_reg |-> mem_wr_addr[14:6] == page_reg)
    else $error("page write left its page");
  refuse_pulse_a: assert property (write_refused |-> wp ##1 !write_refused)
    else $error("refusal without protect or too long");
  cover property ($rose(prog_busy));
  cover property (write_refused);
  cover property (mem_wr_en && wr_seen_reg);
  cover property ($rose(sda_oe));
endmodule

bind eewr_target eewr_target_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_eewr_target_assertions (
  .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .wp(wp), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .prog_busy(prog_busy),
  .write_refused(write_refused)
);

// ### test/eewr_ctrl_model.sv
// two-wire bus controller model driving clock and data
`timescale 1ns/1ps
// ==================
// controller
module eewr_ctrl_model (
  // bus
  output reg  scl,
  output reg  sda_low,
  input  wire sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // clock stands high between frames; the low phase outlasts the target's
  // pin filter, so its answer settles before the next rise
  task clk_bit(input b, output s);
    begin
      #25 sda_low = ~b;
      #200 scl = 1'b1;
      #50 s = sda;
      #75 scl = 1'b0;
    end
  endtask
  // long lead-in lets a pending acknowledge clear before the line rises
  task bus_start;
    begin
      #250 sda_low = 1'b0;
      #50 scl = 1'b1;
      #150 sda_low = 1'b1;
      #150 scl = 1'b0;
      #25;
    end
  endtask
  task bus_stop;
    begin
      #250 sda_low = 1'b1;
      #50 scl = 1'b1;
      #150 sda_low = 1'b0;
      #150;
    end
  endtask
  task put_byte(input [7:0] b, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        clk_bit(b[i], s);
      clk_bit(1'b1, ack);
    end
  endtask
  task get_byte(input ack, output [7:0] b);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(1'b1, s);
        b[i] = s;
      end
      clk_bit(ack, s);
    end
  endtask
endmodule

// ### test/eewr_target_bench.sv
// self-checking bench for the two-wire eeprom write target
`timescale 1ns/1ps
`include "eewr_map.vh"
// ==================
// bench
module eewr_target_bench;
  localparam [23:0] PROG   = 24'd200;
  localparam [2:0]  STRAPS = 3'b101;
  localparam [7:0]  AW     = {`EEWR_TYPE_CODE, STRAPS, 1'b0};
  localparam [7:0]  AR     = {`EEWR_TYPE_CODE, STRAPS, 1'b1};
  reg         core_clk;
  reg         rst_n;
  reg  [2:0]  strap_select_pins;
  reg  [2:0]  strap_open;
  reg         wp;
  reg         ack;
  reg         refused_seen;
  reg  [7:0]  v;
  reg  [7:0]  mem [0:32767];
  reg  [14:0] rows [0:5];
  integer     err_total;
  integer     total_checks;
  integer     i;
  integer     n;
  wire        scl;
  wire        sda_low;
  wire        sda_out;
  wire        sda_oe;
  wire [14:0] mem_rd_addr;
  wire        mem_wr_en;
  wire [14:0] mem_wr_addr;
  wire [7:0]  mem_wr_data;
  wire        prog_busy;
  wire        write_refused;
  // open-drain data line with its pull-up
  wire        sda = ~(sda_low | (sda_oe & ~sda_out));
  eewr_ctrl_model u_eewr_ctrl_model (.scl(scl), .sda_low(sda_low), .sda(sda));
  eewr_target #(.PROG_CYCLES(PROG)) u_eewr_target (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_select_pins(strap_select_pins), .strap_open(strap_open), .wp(wp),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem[mem_rd_addr]),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .prog_busy(prog_busy), .write_refused(write_refused)
  );
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1)
      mem[mem_wr_addr] <= mem_wr_data;
    if (write_refused === 1'b1)
      refused_seen <= 1'b1;
  end
  // ==================
  // helpers
  function [7:0] pat(input [14:0] a);
    pat = a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  function [7:0] dat(input integer k);
    dat = k[7:0] ^ 8'h5a;
  endfunction
  task ck(input [14:0] got, input [14:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (err_total == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task addr(input [7:0] b, input e);
    begin
      u_eewr_ctrl_model.bus_start;
      u_eewr_ctrl_model.put_byte(b, ack);
      ck({14'h0, ack}, {14'h0, e});
    end
  endtask
  task wbyte(input [7:0] b, input e);
    begin
      u_eewr_ctrl_model.put_byte(b, ack);
      ck({14'h0, ack}, {14'h0, e});
    end
  endtask
  task rd(input a, input [7:0] e);
    begin
      u_eewr_ctrl_model.get_byte(a, v);
      ck({7'h0, v}, {7'h0, e});
    end
  endtask
  task wait_busy(input lvl);
    begin
      n = 0;
      while (prog_busy !== lvl && n < 2000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (prog_busy !== lvl) begin
        ck({14'h0, prog_busy}, {14'h0, lvl});
        close_out;
      end
    end
  endtask
  // ==================
  // sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    strap_select_pins = STRAPS;
    strap_open = 3'b000;
    wp = 1'b0;
    refused_seen = 1'b0;
    err_total = 0;
    total_checks = 0;
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = pat(i[14:0]);
    // address byte, straps, unconnected straps, expected acknowledge level
    rows[0] = {AW, 3'b101, 3'b000, 1'b0};
    rows[1] = {`EEWR_TYPE_CODE, 3'b100, 1'b0, 3'b101, 3'b000, 1'b1};
    rows[2] = {4'h6, 3'b101, 1'b0, 3'b101, 3'b000, 1'b1};
    rows[3] = {`EEWR_TYPE_CODE, 3'b001, 1'b0, 3'b101, 3'b100, 1'b0};
    rows[4] = {AW, 3'b101, 3'b100, 1'b1};
    rows[5] = {`EEWR_TYPE_CODE, 3'b011, 1'b0, 3'b011, 3'b000, 1'b0};
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    ck(mem_rd_addr, `EEWR_ADDR_RST);
    ck({11'h0, sda_oe, prog_busy, mem_wr_en, write_refused}, 15'h0);
    repeat (10) @(negedge core_clk);
    for (i = 0; i < 6; i = i + 1) begin
      strap_select_pins = rows[i][6:4];
      strap_open = rows[i][3:1];
      addr(rows[i][14:7], rows[i][0]);
      u_eewr_ctrl_model.bus_stop;
    end
    strap_select_pins = STRAPS;
    strap_open = 3'b000;
    // page write from offset 62: wraps, and the 65th byte overwrites the first
    addr(AW, 1'b0);
    wbyte(8'h92, 1'b0);
    wbyte(8'h3e, 1'b0);
    for (i = 0; i < 65; i = i + 1)
      wbyte(dat(i), 1'b0);
    u_eewr_ctrl_model.bus_stop;
    wait_busy(1'b1);
    addr(AW, 1'b1);
    u_eewr_ctrl_model.bus_stop;
    wait_busy(1'b0);
    addr(AW, 1'b0);
    u_eewr_ctrl_model.bus_stop;
    for (i = 0; i < 64; i = i + 1)
      ck({7'h0, mem[15'h1200 + i]}, {7'h0, dat(i == 62 ? 64 : (i - 62) & 63)});
    ck({7'h0, mem[15'h1240]}, {7'h0, pat(15'h1240)});
    // random read across the page end, protect held high throughout
    wp = 1'b1;
    addr(AW, 1'b0);
    wbyte(8'h12, 1'b0);
    wbyte(8'h3f, 1'b0);
    addr(AR, 1'b0);
    rd(1'b0, dat(1));
    rd(1'b0, pat(15'h1240));
    rd(1'b1, pat(15'h1241));
    u_eewr_ctrl_model.bus_stop;
    // no acknowledge and no stop: target must stay released
    addr(AR, 1'b0);
    u_eewr_ctrl_model.get_byte(1'b1, v);
    rd(1'b1, 8'hff);
    u_eewr_ctrl_model.bus_stop;
    // protected write
    refused_seen = 1'b0;
    addr(AW, 1'b0);
    wbyte(8'h00, 1'b0);
    wbyte(8'h10, 1'b0);
    wbyte(8'hc3, 1'b1);
    u_eewr_ctrl_model.bus_stop;
    repeat (20) @(negedge core_clk);
    ck({14'h0, refused_seen}, 15'h1);
    ck({14'h0, prog_busy}, 15'h0);
    ck({7'h0, mem[15'h0010]}, {7'h0, pat(15'h0010)});
    wp = 1'b0;
    // start three bits into a byte restarts address reception
    addr(AW, 1'b0);
    for (i = 0; i < 3; i = i + 1)
      u_eewr_ctrl_model.clk_bit(1'b0, ack);
    addr(AW, 1'b0);
    wbyte(8'h00, 1'b0);
    wbyte(8'h20, 1'b0);
    wbyte(8'ha5, 1'b0);
    u_eewr_ctrl_model.bus_stop;
    wait_busy(1'b1);
    wait_busy(1'b0);
    ck({7'h0, mem[15'h0020]}, {7'h0, 8'ha5});
    close_out;
  end
endmodule
